// ===== chip_select_decoder.sv
`timescale 1ns/1ps
// Contract
// - Quadrant selects only while power hold low.
// - Quadrant 0 low for 0000H-3FFFH.
// - Quadrant 1 low for 4000H-7FFFH, enables pages.
// - Quadrant 2 low for 8000H-BFFFH option ROM.
// - Quadrant 3 low for C000H-FFFFH system ROM.
// - Pages need primary enable, quadrant 1, aux gate.
// - Page index equals address bits 13..11.
// - Pages 1-4 optional RAM; page 5 unused.
// - Page 6 covers 7000H-77FFH window.
// - Page 7 selects system RAM 7800H-7FFFH.
// - Display selects only while page 6 low.
// - Bit 8 low selects display pair A.
// - Bit 8 high selects display pair B.
// - Display pairs split byte into two nibbles.
// - System RAM nibbles share page 7 select.
// - I/O port at F000H-F00FH secondary space.
// - Bank V steers 8000H-BFFFH primary space.
// - Bank U steers within 8000H-9FFFH only.
// - Machine cycle is half the 2.6MHz crystal.
// - Power-on: init peripherals, check memory, ready.
module chip_select_decoder
  import chip_select_pkg::*;
#(
  parameter int MACHINE_DIV = MACHINE_DIV_DEFAULT
) (
  input wire logic i_clock, // System clock, 50 MHz.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic [15:0] i_address, // Processor address bus.
  input wire logic i_primary_space_enable, // Primary memory space enable, high.
  input wire logic i_delayed_primary_enable, // Delayed primary enable, high.
  input wire logic i_secondary_space_indication, // Secondary space indication, high.
  input wire logic i_power_hold_gate, // Power hold gate, selects only when low.
  input wire logic i_aux_active_low_gate_n, // Auxiliary page gate, normally low.
  input wire logic i_bank_choice_v, // Bank choice V.
  input wire logic i_bank_choice_u, // Bank choice U.
  input wire logic [7:0] i_write_byte, // Byte from the processor for nibble memories.
  input wire logic [3:0] i_read_nibble_lo, // Low nibble read from a nibble memory.
  input wire logic [3:0] i_read_nibble_hi, // High nibble read from a nibble memory.
  input wire logic i_periph_init_done, // Peripheral initialisation finished.
  input wire logic i_mem_check_done, // User ROM and RAM check finished.
  output logic [3:0] o_quadrant_sel_n, // Quadrant selects, active low.
  output logic [7:0] o_page_sel_n, // Page selects, active low.
  output logic o_lcd_pair_sel_a, // Display chips 1 and 3, high.
  output logic o_lcd_pair_sel_b, // Display chips 2 and 4, high.
  output logic o_sysram_sel_lo_n, // System RAM low-nibble part, active low.
  output logic o_sysram_sel_hi_n, // System RAM high-nibble part, active low.
  output logic [3:0] o_write_nibble_lo, // Data bits 0-3 to the low part.
  output logic [3:0] o_write_nibble_hi, // Data bits 4-7 to the high part.
  output logic [7:0] o_read_byte, // Byte built from both nibbles.
  output logic o_io_port_sel, // I/O port controller select, high.
  output logic [3:0] o_io_reg_index, // I/O port controller location.
  output logic o_bank_v_sel, // Banked region with V true.
  output logic o_bank_v_sel_n, // Banked region with V complemented.
  output logic o_bank_u_sel, // U true inside the V bank.
  output logic o_bank_u_sel_n, // U complemented inside the V bank.
  output logic o_xtal_tick, // One-cycle pulse at the crystal rate.
  output logic o_machine_tick, // One-cycle pulse per machine cycle.
  output logic o_init_periph, // Peripheral initialisation in progress.
  output logic o_check_mem, // Memory check in progress.
  output logic o_ready_for_keys // Ready to accept key entry.
);

  // The machine counter must divide by 2 to 255, the crystal counter by at least one; refused at elaboration.
  if (MACHINE_DIV < 2 || MACHINE_DIV > 255 || XTAL_DIV < 1) begin : g_bad_divider
    $error("chip_select_decoder: divider counts out of range");
  end

  typedef enum logic [1:0] {
    ST_INIT_PERIPH,
    ST_CHECK_MEM,
    ST_READY
  } power_state_type;

  // Field extraction for the decoders.
  wire logic [1:0] quad_idx = i_address[QUAD_MSB:QUAD_LSB];
  wire logic [2:0] page_idx = i_address[PAGE_MSB:PAGE_LSB];
  wire logic [1:0] lcd_win = i_address[LCD_WIN_MSB:LCD_WIN_LSB];
  wire logic [1:0] io_space = i_address[IO_SPACE_MSB:IO_SPACE_LSB];

  // First-level decoder: one quadrant low per address while power hold is low.
  wire logic quad_enable = ~i_power_hold_gate;
  wire logic [3:0] quad_next_n = quad_enable ? ~(4'h1 << quad_idx) : QUAD_IDLE_N;

  // Second-level decoder, gated by the quadrant 1 term of this same cycle.
  wire logic page_enable = i_primary_space_enable & ~quad_next_n[QUAD_IDX_PAGED]
                           & ~i_aux_active_low_gate_n;
  // A shifted one-hot keeps at most one page low by construction.
  wire logic [7:0] page_next_n = page_enable ? ~(8'h01 << page_idx) : PAGE_IDLE_N;
  wire logic page6_low = ~page_next_n[PAGE_IDX_LCD];
  wire logic page7_low = ~page_next_n[PAGE_IDX_SYSRAM];

  // Display decoder: enabled only by page 6, and then only in its top 512 bytes.
  wire logic lcd_enable = page6_low & i_delayed_primary_enable & (lcd_win == LCD_WIN_VALUE);
  wire logic lcd_a_next = lcd_enable & ~i_address[LCD_PAIR_BIT];
  wire logic lcd_b_next = lcd_enable & i_address[LCD_PAIR_BIT];

  // I/O port: partial decode, bits 4-11 and 14-15 are not looked at.
  wire logic io_next = i_secondary_space_indication & (io_space == IO_SPACE_VALUE);

  // Bank steering inside the primary space.
  wire logic in_v_region = i_primary_space_enable & (i_address >= BANK_V_FIRST)
                           & (i_address <= BANK_V_LAST);
  wire logic in_u_region = in_v_region & (i_address <= BANK_U_LAST);
  wire logic bank_v_next = in_v_region & i_bank_choice_v;
  wire logic bank_nv_next = in_v_region & ~i_bank_choice_v;
  wire logic bank_u_next = in_u_region & i_bank_choice_v & i_bank_choice_u;
  wire logic bank_nu_next = in_u_region & i_bank_choice_v & ~i_bank_choice_u;

  // Read byte: low lane from bits 0-3, high lane from bits 4-7.
  wire logic [7:0] read_byte_next = {i_read_nibble_hi, i_read_nibble_lo};

  // Select outputs are retimed once so they come from flip-flops. One 20 ns
  // clock is far inside a machine cycle, so the decode still settles within the
  // same bus cycle and carries nothing from one address to the next.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_quadrant_sel_n <= QUAD_IDLE_N;
      o_page_sel_n <= PAGE_IDLE_N;
      o_lcd_pair_sel_a <= LCD_IDLE;
      o_lcd_pair_sel_b <= LCD_IDLE;
      o_sysram_sel_lo_n <= 1'b1;
      o_sysram_sel_hi_n <= 1'b1;
    end else begin
      o_quadrant_sel_n <= quad_next_n;
      o_page_sel_n <= page_next_n;
      o_lcd_pair_sel_a <= lcd_a_next;
      o_lcd_pair_sel_b <= lcd_b_next;
      o_sysram_sel_lo_n <= ~page7_low;
      o_sysram_sel_hi_n <= ~page7_low;
    end
  end

  // Data lanes, port select and bank steering, retimed the same way.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_write_nibble_lo <= 4'h0;
      o_write_nibble_hi <= 4'h0;
      o_read_byte <= 8'h00;
      o_io_port_sel <= 1'b0;
      o_io_reg_index <= 4'h0;
      o_bank_v_sel <= 1'b0;
      o_bank_v_sel_n <= 1'b0;
      o_bank_u_sel <= 1'b0;
      o_bank_u_sel_n <= 1'b0;
    end else begin
      o_write_nibble_lo <= i_write_byte[3:0];
      o_write_nibble_hi <= i_write_byte[7:4];
      o_read_byte <= read_byte_next;
      o_io_port_sel <= io_next;
      o_io_reg_index <= i_address[IO_INDEX_MSB:0];
      o_bank_v_sel <= bank_v_next;
      o_bank_v_sel_n <= bank_nv_next;
      o_bank_u_sel <= bank_u_next;
      o_bank_u_sel_n <= bank_nu_next;
    end
  end

  // Crystal and machine-cycle ticks from one clock; the machine tick is the
  // crystal rate halved, rounded to whole system clocks.
  logic [7:0] xtal_count_reg;
  logic [7:0] mc_count_reg;
  wire logic xtal_wrap = (xtal_count_reg == 8'(XTAL_DIV - 1));
  wire logic mc_wrap = (mc_count_reg == 8'(MACHINE_DIV - 1));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      xtal_count_reg <= 8'h00;
      mc_count_reg <= 8'h00;
      o_xtal_tick <= 1'b0;
      o_machine_tick <= 1'b0;
    end else begin
      xtal_count_reg <= xtal_wrap ? 8'h00 : xtal_count_reg + 8'h01;
      mc_count_reg <= mc_wrap ? 8'h00 : mc_count_reg + 8'h01;
      o_xtal_tick <= xtal_wrap;
      o_machine_tick <= mc_wrap;
    end
  end

  // Power-on order: peripherals first, then the memory check, then keys.
  power_state_type power_state_reg;
  power_state_type power_state_next;

  always_comb begin
    power_state_next = power_state_reg;
    unique case (power_state_reg)
      ST_INIT_PERIPH: begin
        if (i_periph_init_done) begin
          power_state_next = ST_CHECK_MEM;
        end
      end
      ST_CHECK_MEM: begin
        if (i_mem_check_done) begin
          power_state_next = ST_READY;
        end
      end
      ST_READY: begin
        power_state_next = ST_READY;
      end
    endcase
  end

  // Status outputs are registered alongside the state so they stay glitch free.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      power_state_reg <= ST_INIT_PERIPH;
      o_init_periph <= 1'b1;
      o_check_mem <= 1'b0;
      o_ready_for_keys <= 1'b0;
    end else begin
      power_state_reg <= power_state_next;
      o_init_periph <= (power_state_next == ST_INIT_PERIPH);
      o_check_mem <= (power_state_next == ST_CHECK_MEM);
      o_ready_for_keys <= (power_state_next == ST_READY);
    end
  end

  // Checks on the registered outputs, against each other or against the inputs one clock earlier.
  property p_quad_gated;
    @(posedge i_clock) disable iff (!i_nrst)
      i_power_hold_gate |=> (o_quadrant_sel_n == QUAD_IDLE_N);
  endproperty
  a_quad_gated: assert property (p_quad_gated) else $error("quadrant select while power hold high");

  property p_quad_one;
    @(posedge i_clock) disable iff (!i_nrst)
      !i_power_hold_gate |=> ($countones(~o_quadrant_sel_n) == 1)
        && !o_quadrant_sel_n[$past(i_address[15:14])];
  endproperty
  a_quad_one: assert property (p_quad_one) else $error("quadrant select does not match address");

  property p_page_needs_enable;
    @(posedge i_clock) disable iff (!i_nrst)
      (!i_primary_space_enable || i_aux_active_low_gate_n || i_address[15:14] != 2'h1)
        |=> (o_page_sel_n == PAGE_IDLE_N);
  endproperty
  a_page_needs_enable: assert property (p_page_needs_enable) else $error("page select without enable");

  property p_page_index;
    @(posedge i_clock) disable iff (!i_nrst)
      (i_primary_space_enable && !i_aux_active_low_gate_n && !i_power_hold_gate
        && i_address[15:14] == 2'h1) |=> !o_page_sel_n[$past(i_address[13:11])];
  endproperty
  a_page_index: assert property (p_page_index) else $error("wrong page select for address");

  property p_page_single;
    @(posedge i_clock) disable iff (!i_nrst)
      $countones(~o_page_sel_n) <= 1 && !(o_lcd_pair_sel_a && o_lcd_pair_sel_b);
  endproperty
  a_page_single: assert property (p_page_single) else $error("two selects active together");

  property p_lcd_needs_page6;
    @(posedge i_clock) disable iff (!i_nrst)
      (o_lcd_pair_sel_a || o_lcd_pair_sel_b) |-> !o_page_sel_n[6];
  endproperty
  a_lcd_needs_page6: assert property (p_lcd_needs_page6) else $error("display select without page 6");

  property p_lcd_pair;
    @(posedge i_clock) disable iff (!i_nrst)
      o_lcd_pair_sel_b |-> $past(i_address[8]) && $past(i_delayed_primary_enable);
  endproperty
  a_lcd_pair: assert property (p_lcd_pair) else $error("display pair B without bit 8 high");

  property p_sysram_shared;
    @(posedge i_clock) disable iff (!i_nrst)
      (o_sysram_sel_lo_n == o_page_sel_n[7]) && (o_sysram_sel_hi_n == o_page_sel_n[7]);
  endproperty
  a_sysram_shared: assert property (p_sysram_shared) else $error("system RAM parts not on page 7");

  property p_io_decode;
    @(posedge i_clock) disable iff (!i_nrst)
      (i_secondary_space_indication && i_address[13:12] == 2'h3)
        |=> o_io_port_sel && o_io_reg_index == $past(i_address[3:0]);
  endproperty
  a_io_decode: assert property (p_io_decode) else $error("I/O port not selected");

  property p_bank_u_inside_v;
    @(posedge i_clock) disable iff (!i_nrst)
      (o_bank_u_sel || o_bank_u_sel_n) |-> o_bank_v_sel && $past(i_address[15:13]) == 3'h4;
  endproperty
  a_bank_u_inside_v: assert property (p_bank_u_inside_v) else $error("bank U outside its region");

  sequence s_mc_tick;
    o_machine_tick ##1 !o_machine_tick [*8];
  endsequence

  property p_mc_spacing;
    @(posedge i_clock) disable iff (!i_nrst)
      o_machine_tick |-> s_mc_tick ##30 o_machine_tick;
  endproperty
  a_mc_spacing: assert property (p_mc_spacing) else $error("machine tick spacing wrong");

  sequence s_init_to_check;
    o_init_periph ##1 o_check_mem;
  endsequence

  property p_power_order;
    @(posedge i_clock) disable iff (!i_nrst)
      $rose(o_ready_for_keys) |-> $past(o_check_mem) && !o_init_periph;
  endproperty
  a_power_order: assert property (p_power_order) else $error("ready before memory check");

  property p_check_after_init;
    @(posedge i_clock) disable iff (!i_nrst)
      $rose(o_check_mem) |-> $past(o_init_periph, 1);
  endproperty
  a_check_after_init: assert property (p_check_after_init) else $error("memory check before init");

  property p_lcd_pair_a;
    @(posedge i_clock) disable iff (!i_nrst)
      o_lcd_pair_sel_a |-> !$past(i_address[8]) && $past(i_delayed_primary_enable);
  endproperty
  a_lcd_pair_a: assert property (p_lcd_pair_a) else $error("display pair A without bit 8 low");

  property p_page6_window;
    @(posedge i_clock) disable iff (!i_nrst)
      !o_page_sel_n[6] |-> $past(i_address[15:11]) == 5'h0E;
  endproperty
  a_page6_window: assert property (p_page6_window) else $error("page 6 outside its window");

  property p_page7_window;
    @(posedge i_clock) disable iff (!i_nrst)
      !o_page_sel_n[7] |-> $past(i_address[15:11]) == 5'h0F;
  endproperty
  a_page7_window: assert property (p_page7_window) else $error("page 7 outside its window");

  property p_bank_v_region;
    @(posedge i_clock) disable iff (!i_nrst)
      (o_bank_v_sel || o_bank_v_sel_n) |-> !(o_bank_v_sel && o_bank_v_sel_n)
        && $past(i_primary_space_enable) && $past(i_address[15:14]) == 2'h2;
  endproperty
  a_bank_v_region: assert property (p_bank_v_region) else $error("bank V outside its region");

  // The crystal tick has its own spacing; its counter runs apart from the machine-cycle counter.
  sequence s_xtal_tick;
    o_xtal_tick ##1 !o_xtal_tick [*8];
  endsequence

  property p_xtal_spacing;
    @(posedge i_clock) disable iff (!i_nrst)
      o_xtal_tick |-> s_xtal_tick ##11 o_xtal_tick;
  endproperty
  a_xtal_spacing: assert property (p_xtal_spacing) else $error("crystal tick spacing wrong");

endmodule // chip_select_decoder

// ===== chip_select_pkg.sv
package chip_select_pkg;

  // Address fields that the decoders look at.
  localparam int QUAD_MSB = 15;
  localparam int QUAD_LSB = 14;
  localparam int PAGE_MSB = 13;
  localparam int PAGE_LSB = 11;
  localparam int LCD_WIN_MSB = 10;
  localparam int LCD_WIN_LSB = 9;
  localparam int LCD_PAIR_BIT = 8;
  localparam int IO_SPACE_MSB = 13;
  localparam int IO_SPACE_LSB = 12;
  localparam int IO_INDEX_MSB = 3;

  // Decoded values of those fields.
  localparam logic [1:0] QUAD_IDX_PAGED = 2'h1;
  localparam logic [2:0] PAGE_IDX_LCD = 3'h6;
  localparam logic [2:0] PAGE_IDX_SYSRAM = 3'h7;
  localparam logic [1:0] LCD_WIN_VALUE = 2'h3;
  localparam logic [1:0] IO_SPACE_VALUE = 2'h3;

  // Banked region of the primary space.
  localparam logic [15:0] BANK_V_FIRST = 16'h8000;
  localparam logic [15:0] BANK_V_LAST = 16'hBFFF;
  localparam logic [15:0] BANK_U_LAST = 16'h9FFF;

  // Values after reset: every select idle.
  localparam logic [3:0] QUAD_IDLE_N = 4'hF;
  localparam logic [7:0] PAGE_IDLE_N = 8'hFF;
  localparam logic LCD_IDLE = 1'b0;

  // Clock rates and the divider counts derived from them.
  localparam int CLOCK_HZ = 50000000;
  localparam int XTAL_HZ = 2600000;
  localparam int MACHINE_HZ = XTAL_HZ / 2;
  localparam int XTAL_DIV = CLOCK_HZ / XTAL_HZ;
  localparam int MACHINE_DIV_DEFAULT = CLOCK_HZ / MACHINE_HZ;

endpackage

// ===== cpu_bus_model.sv
`timescale 1ns/1ps
// Processor side of the decoder: presents one address and its space enables per bus cycle.
module cpu_bus_model (
  input wire logic i_clock, // System clock.
  output logic [15:0] o_address, // Address bus.
  output logic o_primary_space_enable, // Primary space enable, high.
  output logic o_delayed_primary_enable, // Delayed primary enable, high.
  output logic o_secondary_space_indication // Secondary space indication, high.
);
  // The bus starts with both spaces disabled so that only a quadrant select can come from a stale address.
  initial begin
    o_address = 16'h0000;
    o_primary_space_enable = 1'b0;
    o_delayed_primary_enable = 1'b0;
    o_secondary_space_indication = 1'b0;
  end

  // Called just after a rising edge; the values then stand for the whole bus cycle.
  task automatic drive(input logic [15:0] addr, input logic pe, input logic de, input logic se);
    o_address = addr;
    o_primary_space_enable = pe;
    o_delayed_primary_enable = de;
    o_secondary_space_indication = se;
  endtask
endmodule // cpu_bus_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import chip_select_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, pe, de, se, hold = 1'b0, aux_n = 1'b0, bv_in = 1'b0, bu_in = 1'b0;
  logic [15:0] addr;
  logic [7:0] wbyte = 8'h00;
  logic [3:0] rlo = 4'h0, rhi = 4'h0;
  logic pdone = 1'b0, mdone = 1'b0;
  logic [3:0] quad_n, wlo, whi, io_idx;
  logic [7:0] page_n, rbyte;
  logic lcd_a, lcd_b, sr_lo_n, sr_hi_n, io_sel, bv, bvn, bu, bun, xt, mt, st_init, st_check, st_ready;
  int error_cnt = 0, checked = 0, cycles = 0;
  logic [15:0] corners [0:21] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h47FF, 16'h4800, 16'h5000, 16'h5800,
    16'h6000, 16'h6800, 16'h7000, 16'h75FF, 16'h7600, 16'h76FF, 16'h7700, 16'h77FF, 16'h7800, 16'h7FFF,
    16'h8000, 16'h9FFF, 16'hA000, 16'hBFFF, 16'hF00F};

  cpu_bus_model i_cpu_bus_model (.i_clock(clk), .o_address(addr), .o_primary_space_enable(pe),
    .o_delayed_primary_enable(de), .o_secondary_space_indication(se));

  chip_select_decoder i_chip_select_decoder (.i_clock(clk), .i_nrst(nrst), .i_address(addr),
    .i_primary_space_enable(pe), .i_delayed_primary_enable(de), .i_secondary_space_indication(se),
    .i_power_hold_gate(hold), .i_aux_active_low_gate_n(aux_n), .i_bank_choice_v(bv_in),
    .i_bank_choice_u(bu_in), .i_write_byte(wbyte), .i_read_nibble_lo(rlo), .i_read_nibble_hi(rhi),
    .i_periph_init_done(pdone), .i_mem_check_done(mdone), .o_quadrant_sel_n(quad_n),
    .o_page_sel_n(page_n), .o_lcd_pair_sel_a(lcd_a), .o_lcd_pair_sel_b(lcd_b),
    .o_sysram_sel_lo_n(sr_lo_n), .o_sysram_sel_hi_n(sr_hi_n), .o_write_nibble_lo(wlo),
    .o_write_nibble_hi(whi), .o_read_byte(rbyte), .o_io_port_sel(io_sel), .o_io_reg_index(io_idx),
    .o_bank_v_sel(bv), .o_bank_v_sel_n(bvn), .o_bank_u_sel(bu), .o_bank_u_sel_n(bun),
    .o_xtal_tick(xt), .o_machine_tick(mt), .o_init_periph(st_init), .o_check_mem(st_check),
    .o_ready_for_keys(st_ready));

  // The clock toggles every half period of 10 ns.
  always #10 clk = ~clk;

  // A hang is cut short well after the planned sequence should have ended.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      complete_run();
    end
  end

  // Every comparison goes through here so that counting and reporting stay uniform.
  task automatic compare(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Expectations are rebuilt from the held inputs after the edge that sampled them.
  task automatic check_decode;
    logic [3:0] q;
    logic [7:0] p;
    logic vr, ur, win;
    q = 4'hF;
    if (!hold) q[addr[15:14]] = 1'b0;
    p = 8'hFF;
    if (!q[1] && pe && !aux_n) p[addr[13:11]] = 1'b0;
    win = !p[6] && de && addr[10:9] == 2'h3;
    vr = pe && addr >= BANK_V_FIRST && addr <= BANK_V_LAST;
    ur = vr && addr <= BANK_U_LAST;
    compare("quadrant", {12'h000, quad_n}, {12'h000, q});
    compare("page", {8'h00, page_n}, {8'h00, p});
    compare("lcd pair", {14'h0000, lcd_a, lcd_b},
      {14'h0000, win && !addr[8], win && addr[8]});
    compare("sysram", {14'h0000, sr_lo_n, sr_hi_n}, {14'h0000, p[7], p[7]});
    compare("nibbles", {whi, wlo, rbyte}, {wbyte, rhi, rlo});
    compare("io port", {11'h000, io_sel, io_idx}, {11'h000, se && addr[13:12] == 2'h3, addr[3:0]});
    compare("bank", {12'h000, bv, bvn, bu, bun}, {12'h000, vr && bv_in, vr && !bv_in, ur && bv_in && bu_in,
      ur && bv_in && !bu_in});
  endtask

  // One vector per bus cycle, back to back, changed just after the rising edge.
  task automatic apply(input logic [15:0] a, input logic [2:0] en);
    i_cpu_bus_model.drive(a, en[2], en[1], en[0]);
    @(posedge clk);
    #1;
    check_decode();
  endtask

  // A done input is held for exactly one sampling edge.
  task automatic pulse_done(input bit mem, input logic [2:0] exp);
    pdone = !mem;
    mdone = mem;
    @(posedge clk);
    #1;
    pdone = 1'b0;
    mdone = 1'b0;
    compare("power state", {13'h0000, st_init, st_check, st_ready}, {13'h0000, exp});
  endtask

  // Measures the spacing between two consecutive one-cycle tick pulses.
  task automatic tick_gap(input bit mach, input int exp);
    int n;
    n = 0;
    while ((mach ? mt : xt) !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((mach ? mt : xt) !== 1'b1 && n < 100);
    compare("tick gap", 16'(n), 16'(exp));
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: power-on order, ticks, boundary table, page sweep, then random traffic.
  initial begin
    logic [31:0] r;
    void'($urandom(32'h90e699b1));
    repeat (10) @(posedge clk);
    #1;
    compare("power state", {13'h0000, st_init, st_check, st_ready}, 16'h0004);
    nrst = 1'b1;
    pulse_done(1'b1, 3'b100);
    pulse_done(1'b0, 3'b010);
    pulse_done(1'b1, 3'b001);
    pulse_done(1'b0, 3'b001);
    tick_gap(1'b1, MACHINE_DIV_DEFAULT);
    tick_gap(1'b0, XTAL_DIV);
    // Each boundary is tried open, with the hold gate up, with the page gate up and without enables.
    for (int i = 0; i < 22; i++) begin
      for (int m = 0; m < 4; m++) begin
        hold = (m == 1);
        aux_n = (m == 2);
        bv_in = i[0];
        bu_in = i[1];
        apply(corners[i], (m == 3) ? 3'b000 : 3'b111);
      end
    end
    hold = 1'b0;
    aux_n = 1'b0;
    for (int p = 0; p < 8; p++) apply(16'h4000 + 16'(p) * 16'h0800 + 16'h07FF, 3'b110);
    repeat (400) begin
      r = $urandom;
      hold = ($urandom % 8) == 0;
      aux_n = ($urandom % 8) == 0;
      bv_in = r[16];
      bu_in = r[17];
      wbyte = r[25:18];
      rlo = r[29:26];
      rhi = {r[31:30], r[1:0]};
      apply(r[15:0], 3'($urandom));
    end
    complete_run();
  end
endmodule // tb
